// file: logic/dac_core.sv
// Descriptor address check: stack adjust, address forming, protection.
// Assumes operator sequencer and memory on core_clk; memory acks in-domain.
`timescale 1ns/1ps
module dac_core
  import dac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Stack adjustment request and stack register state
  input wire logic adj_req,
  input wire logic [2:0] adj_target,
  input wire logic push_word_valid,
  input wire logic [DAC_WORD_W-1:0] push_word,
  output logic adj_busy,
  output logic op_stall,
  output logic top_reg_valid,
  output logic second_reg_valid,
  output logic [DAC_WORD_W-1:0] top_word,
  output logic [DAC_WORD_W-1:0] second_word,
  output logic [DAC_ADDR_W-1:0] stack_ptr,
  // Reference request
  input wire logic ref_req,
  input wire dac_ref_e ref_kind,
  input wire logic ref_store,
  input wire logic [DAC_ADDR_W-1:0] ref_addr,
  input wire logic [DAC_ADDR_W-1:0] display_base,
  input wire logic [DAC_ADDR_W-1:0] stack_base,
  input wire logic desc_present,
  input wire logic desc_indexed,
  input wire logic desc_double,
  input wire logic desc_readonly,
  input wire logic [DAC_LEN_W-1:0] desc_length,
  input wire logic [DAC_ADDR_W-1:0] master_addr,
  input wire logic index_req,
  input wire logic copy_req,
  input wire logic signed [DAC_IDX_W-1:0] index_val,
  // Reference result
  output logic ref_done,
  output logic [DAC_ADDR_W-1:0] abs_addr,
  output logic out_indexed,
  output logic [DAC_LEN_W-1:0] out_length,
  output logic out_copy,
  output logic [DAC_ADDR_W-1:0] out_addr,
  output logic intr,
  output dac_cause_e intr_cause,
  // Main memory
  output logic mem_req,
  output logic mem_we,
  output logic [DAC_ADDR_W-1:0] mem_addr,
  output logic [DAC_WORD_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DAC_WORD_W-1:0] mem_rdata
);

  // ----------------------------------------
  // Stack adjustment decode
  // ----------------------------------------
  function automatic logic [1:0] dac_goal(input logic [2:0] t, input logic a, input logic b);
    logic [1:0] g;
    g = {a, b};
    unique case (t)
      DAC_ADJ_00: g = 2'h0;
      DAC_ADJ_01: g = 2'h1;
      DAC_ADJ_10: g = 2'h2;
      DAC_ADJ_11: g = 2'h3;
      DAC_ADJ_02: g = {1'b0, a | b};
      DAC_ADJ_12: g = {1'b1, a & b};
      DAC_ADJ_13: g = (a | b) ? {a, b} : 2'h2;
      default: g = {a, b};
    endcase
    return g;
  endfunction

  dac_state_e state_reg, state_next;
  logic [2:0] target_reg;
  logic a_reg, b_reg;
  logic [DAC_WORD_W-1:0] aw_reg, bw_reg;
  logic [DAC_ADDR_W-1:0] sp_reg;
  logic mreq_reg, mwe_reg;
  logic [DAC_ADDR_W-1:0] maddr_reg;
  logic [DAC_WORD_W-1:0] mwdata_reg;
  logic pend_in_reg;

  wire logic [1:0] goal = dac_goal(target_reg, a_reg, b_reg);
  wire logic at_goal = ({a_reg, b_reg} == goal) && !pend_in_reg;
  // Need to drop a register to memory: more valid than wanted, or room for incoming word
  wire logic need_down = (a_reg & b_reg & (pend_in_reg | (goal != 2'h3))) |
                         (b_reg & !a_reg & (goal == 2'h0)) |
                         (a_reg & !b_reg & (goal == 2'h0));
  // Lone top word moves into second without touching memory
  wire logic move_to_second = a_reg & !b_reg & !pend_in_reg & (goal == 2'h1);
  wire logic need_up = !need_down && !pend_in_reg && !move_to_second && (goal[1] & !a_reg | goal[0] & !b_reg);
  // Word sent on push-down: second if full, else the lone occupant
  wire logic [DAC_WORD_W-1:0] down_word = b_reg ? bw_reg : aw_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DAC_ST_IDLE: if (adj_req) state_next = DAC_ST_ADJ;
      DAC_ST_ADJ: if (at_goal) state_next = DAC_ST_IDLE;
                  else if (need_down | need_up) state_next = DAC_ST_MEM;
      DAC_ST_MEM: if (mem_ack) state_next = DAC_ST_ADJ;
      default: state_next = DAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= DAC_ST_IDLE;
      target_reg <= DAC_ADJ_00;
      pend_in_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (state_reg == DAC_ST_IDLE && adj_req) begin
        target_reg <= adj_target;
        pend_in_reg <= push_word_valid;
      end else if (state_reg == DAC_ST_ADJ && pend_in_reg && !(a_reg & b_reg)) begin
        pend_in_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Occupancy flags, registers, stack pointer
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      aw_reg <= DAC_WORD_ZERO;
      bw_reg <= DAC_WORD_ZERO;
      sp_reg <= DAC_SP_RESET;
      mreq_reg <= 1'b0;
      mwe_reg <= 1'b0;
      maddr_reg <= DAC_ADDR_ZERO;
      mwdata_reg <= DAC_WORD_ZERO;
    end else if (clk_en) begin
      if (state_reg == DAC_ST_ADJ && !at_goal) begin
        if (pend_in_reg && !(a_reg & b_reg)) begin
          // Incoming word becomes top, old top slides to second
          aw_reg <= push_word;
          a_reg <= 1'b1;
          if (a_reg) begin
            bw_reg <= aw_reg;
            b_reg <= 1'b1;
          end
        end else if (move_to_second) begin
          bw_reg <= aw_reg;
          b_reg <= 1'b1;
          a_reg <= 1'b0;
        end else if (need_down) begin
          mreq_reg <= 1'b1;
          mwe_reg <= 1'b1;
          maddr_reg <= sp_reg + DAC_SP_STEP;
          mwdata_reg <= down_word;
        end else if (need_up) begin
          mreq_reg <= 1'b1;
          mwe_reg <= 1'b0;
          maddr_reg <= sp_reg;
        end
      end else if (state_reg == DAC_ST_MEM && mem_ack) begin
        mreq_reg <= 1'b0;
        if (mwe_reg) begin
          sp_reg <= sp_reg + DAC_SP_STEP;
          if (b_reg) begin
            b_reg <= 1'b0;
          end else begin
            a_reg <= 1'b0;
          end
          if (a_reg & b_reg) begin
            bw_reg <= aw_reg;
            b_reg <= 1'b1;
            a_reg <= 1'b0;
          end
        end else begin
          sp_reg <= sp_reg - DAC_SP_STEP;
          if (goal[0] & !b_reg) begin
            bw_reg <= mem_rdata;
            b_reg <= 1'b1;
          end else if (b_reg) begin
            aw_reg <= bw_reg;
            a_reg <= 1'b1;
            bw_reg <= mem_rdata;
          end else begin
            aw_reg <= mem_rdata;
            a_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Stall held from request until the target occupancy is reached
  wire logic busy_next = (state_next != DAC_ST_IDLE);
  logic busy_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------
  // Reference checking and address forming
  // ----------------------------------------
  wire logic is_locator = (ref_kind == DAC_REF_ARRAY) || (ref_kind == DAC_REF_SEGMENT);
  wire logic signed [DAC_IDX_W:0] idx_scaled = desc_double ? (DAC_IDX_W+1)'(index_val) <<< 1
                                                          : (DAC_IDX_W+1)'(index_val);
  wire logic idx_neg = idx_scaled < 0;
  wire logic idx_over = !idx_neg && (idx_scaled > $signed({2'b00, desc_length}));
  wire logic idx_bad = index_req && (idx_neg || idx_over);
  wire logic absent = is_locator && !desc_present && !copy_req;
  wire logic ro_block = is_locator && ref_store && desc_readonly;
  wire logic [DAC_ADDR_W-1:0] idx_field = idx_scaled[DAC_ADDR_W-1:0];
  wire logic [DAC_ADDR_W-1:0] rel_sum_local = display_base + ref_addr;
  wire logic [DAC_ADDR_W-1:0] rel_sum_base = stack_base + ref_addr;
  // Absolute locator address: an index request adds the index field, else an indexed descriptor adds its length field
  wire logic [DAC_ADDR_W-1:0] loc_addr = (desc_indexed || index_req) ? ref_addr + (index_req ? idx_field
                                         : desc_length) : ref_addr;
  wire dac_cause_e cause_w = absent ? DAC_CAUSE_PRESENCE :
                             idx_bad ? DAC_CAUSE_INDEX :
                             ro_block ? DAC_CAUSE_READONLY : DAC_CAUSE_NONE;
  wire logic [DAC_ADDR_W-1:0] addr_w = (ref_kind == DAC_REF_LOCAL) ? rel_sum_local :
                                       (ref_kind == DAC_REF_STACKBASE) ? rel_sum_base : loc_addr;

  logic done_reg, intr_reg, idxo_reg, copy_reg;
  dac_cause_e cause_reg;
  logic [DAC_ADDR_W-1:0] abs_reg, oaddr_reg;
  logic [DAC_LEN_W-1:0] olen_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
      intr_reg <= 1'b0;
      cause_reg <= DAC_CAUSE_NONE;
      abs_reg <= DAC_ADDR_ZERO;
      idxo_reg <= 1'b0;
      olen_reg <= DAC_ADDR_ZERO;
      copy_reg <= 1'b0;
      oaddr_reg <= DAC_ADDR_ZERO;
    end else if (clk_en) begin
      done_reg <= ref_req && !busy_reg;
      intr_reg <= ref_req && !busy_reg && (cause_w != DAC_CAUSE_NONE);
      if (ref_req && !busy_reg) begin
        cause_reg <= cause_w;
        abs_reg <= (cause_w == DAC_CAUSE_NONE) ? addr_w : DAC_ADDR_ZERO;
        idxo_reg <= desc_indexed | (index_req & !idx_bad);
        olen_reg <= (index_req && !idx_bad) ? idx_field : desc_length;
        copy_reg <= copy_req && !desc_present;
        oaddr_reg <= (copy_req && !desc_present) ? master_addr : ref_addr;
      end
    end
  end

  assign adj_busy = busy_reg;
  assign op_stall = busy_reg;
  assign top_reg_valid = a_reg;
  assign second_reg_valid = b_reg;
  assign top_word = aw_reg;
  assign second_word = bw_reg;
  assign stack_ptr = sp_reg;
  assign ref_done = done_reg;
  assign abs_addr = abs_reg;
  assign out_indexed = idxo_reg;
  assign out_length = olen_reg;
  assign out_copy = copy_reg;
  assign out_addr = oaddr_reg;
  assign intr = intr_reg;
  assign intr_cause = cause_reg;
  assign mem_req = mreq_reg;
  assign mem_we = mwe_reg;
  assign mem_addr = maddr_reg;
  assign mem_wdata = mwdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stall_adj;
    @(posedge core_clk) disable iff (rst)
      (clk_en && state_reg == DAC_ST_IDLE && adj_req) |=> op_stall;
  endproperty
  a_stall_adj: assert property (p_stall_adj) else $error("stall missing during adjust");

  property p_presence;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && absent) |=> (intr && intr_cause == DAC_CAUSE_PRESENCE);
  endproperty
  a_presence: assert property (p_presence) else $error("presence interrupt missing");

  property p_index_bad;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && !absent && index_req && idx_neg) |=> (intr && intr_cause == DAC_CAUSE_INDEX);
  endproperty
  a_index_bad: assert property (p_index_bad) else $error("negative index accepted");

  property p_index_ok;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && index_req && !idx_bad) |=> (out_indexed && out_length == $past(idx_field));
  endproperty
  a_index_ok: assert property (p_index_ok) else $error("valid index not recorded");

  property p_readonly;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && ro_block && !absent && !idx_bad) |=> (intr && intr_cause == DAC_CAUSE_READONLY);
  endproperty
  a_readonly: assert property (p_readonly) else $error("read-only store not blocked");

  property p_copy;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && copy_req && !desc_present) |=> (out_copy && out_addr == $past(master_addr));
  endproperty
  a_copy: assert property (p_copy) else $error("copy link wrong");

  property p_local;
    @(posedge core_clk) disable iff (rst)
      (clk_en && ref_req && !busy_reg && ref_kind == DAC_REF_LOCAL) |=> (abs_addr == $past(rel_sum_local));
  endproperty
  a_local: assert property (p_local) else $error("local address wrong");

  property p_push_down;
    @(posedge core_clk) disable iff (rst)
      (clk_en && mem_ack && state_reg == DAC_ST_MEM && mem_we) |=> (stack_ptr == $past(sp_reg) + DAC_SP_STEP);
  endproperty
  a_push_down: assert property (p_push_down) else $error("stack pointer not advanced");

  c_adjust: cover property (@(posedge core_clk) disable iff (rst) op_stall ##1 !op_stall);
  c_pres: cover property (@(posedge core_clk) disable iff (rst) intr && intr_cause == DAC_CAUSE_PRESENCE);
  c_idx: cover property (@(posedge core_clk) disable iff (rst) ref_done && out_indexed && !intr);
  c_mem: cover property (@(posedge core_clk) disable iff (rst) mem_req && mem_we);

endmodule

// file: logic/dac_pkg.sv
// Constants and types for the descriptor address check block.
// Assumes a single core clock domain; used by the block's module, its memory model and its testbench.
package dac_pkg;
  localparam int DAC_ADDR_W = 20;
  localparam int DAC_LEN_W = 20;
  localparam int DAC_IDX_W = 21;
  localparam int DAC_WORD_W = 48;
  localparam logic [20:0] DAC_IDX_ZERO = 21'h000000;
  localparam logic [19:0] DAC_ADDR_ZERO = 20'h00000;
  localparam logic [47:0] DAC_WORD_ZERO = 48'h000000000000;
  localparam logic [19:0] DAC_SP_RESET = 20'h00000;
  localparam logic [19:0] DAC_SP_STEP = 20'h00001;
  // Target occupancy codes: bit 1 = top, bit 0 = second, 2/3 forms below
  localparam logic [2:0] DAC_ADJ_00 = 3'h0;
  localparam logic [2:0] DAC_ADJ_01 = 3'h1;
  localparam logic [2:0] DAC_ADJ_10 = 3'h2;
  localparam logic [2:0] DAC_ADJ_11 = 3'h3;
  localparam logic [2:0] DAC_ADJ_02 = 3'h4;
  localparam logic [2:0] DAC_ADJ_12 = 3'h5;
  localparam logic [2:0] DAC_ADJ_13 = 3'h6;
  typedef enum logic [1:0] {
    DAC_REF_ARRAY = 2'h0,
    DAC_REF_SEGMENT = 2'h1,
    DAC_REF_LOCAL = 2'h2,
    DAC_REF_STACKBASE = 2'h3
  } dac_ref_e;
  typedef enum logic [1:0] {
    DAC_CAUSE_NONE = 2'h0,
    DAC_CAUSE_PRESENCE = 2'h1,
    DAC_CAUSE_INDEX = 2'h2,
    DAC_CAUSE_READONLY = 2'h3
  } dac_cause_e;
  typedef enum logic [1:0] {
    DAC_ST_IDLE = 2'h0,
    DAC_ST_ADJ = 2'h1,
    DAC_ST_MEM = 2'h2
  } dac_state_e;
endpackage

// file: verification/dac_mem_model.sv
// Main memory model that answers the block's push-up and push-down traffic.
// Assumes a request is held until acknowledged, all on core_clk.
`timescale 1ns/1ps
module dac_mem_model
  import dac_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Answer delay in cycles
  input wire logic [3:0] latency,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [DAC_ADDR_W-1:0] mem_addr,
  input wire logic [DAC_WORD_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [DAC_WORD_W-1:0] mem_rdata
);
  logic [DAC_WORD_W-1:0] mem [0:255];
  logic [3:0] wait_reg;
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    // Read data is only valid alongside the acknowledge
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_reg <= 4'h0;
      mem_rdata <= DAC_WORD_ZERO;
    end else if (mem_req && !mem_ack) begin
      if (wait_reg >= latency) begin
        wait_reg <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[7:0]];
      end else wait_reg <= wait_reg + 4'h1;
    end else wait_reg <= 4'h0;
  end
endmodule

// file: verification/dac_core_test.sv
// Testbench for the descriptor address check block and its memory model.
// Assumes package constants and a 200 MHz core clock.
`timescale 1ns/1ps
module dac_core_test;
  import dac_pkg::*;
  localparam logic [19:0] BASE = 20'hF0010;
  localparam logic [19:0] MASTER = 20'h0ABCD;
  localparam logic [47:0] W1 = 48'hA5A51234C3C3;
  localparam logic [47:0] W2 = 48'h0F0F5678E1E1;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic adj_req = 1'b0, push_word_valid = 1'b0, ref_req = 1'b0, ref_store = 1'b0, index_req = 1'b0;
  logic desc_present = 1'b0, desc_indexed = 1'b0, desc_double = 1'b0, desc_readonly = 1'b0, copy_req = 1'b0;
  logic [2:0] adj_target = DAC_ADJ_00;
  logic [47:0] push_word = 48'h000000000000;
  dac_ref_e ref_kind = DAC_REF_ARRAY;
  logic [19:0] desc_length = 20'h00000;
  logic signed [20:0] index_val = 21'sh000000;
  logic [3:0] latency = 4'h0;
  logic adj_busy, op_stall, top_reg_valid, second_reg_valid, ref_done, out_indexed, out_copy, intr;
  logic mem_req, mem_we, mem_ack;
  logic [47:0] top_word, second_word, mem_wdata, mem_rdata;
  logic [19:0] stack_ptr, abs_addr, out_length, out_addr, mem_addr;
  dac_cause_e intr_cause;
  int n_errors = 0;
  int samples_checked = 0;

  dac_core dac_core_i (.core_clk, .rst, .clk_en, .adj_req, .adj_target, .push_word_valid, .push_word,
    .adj_busy, .op_stall, .top_reg_valid, .second_reg_valid, .top_word, .second_word, .stack_ptr,
    .ref_req, .ref_kind, .ref_store, .ref_addr(BASE), .display_base(20'h00200), .stack_base(20'h03000),
    .desc_present, .desc_indexed, .desc_double, .desc_readonly, .desc_length, .master_addr(MASTER),
    .index_req, .copy_req, .index_val, .ref_done, .abs_addr, .out_indexed, .out_length, .out_copy,
    .out_addr, .intr, .intr_cause, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  dac_mem_model dac_mem_model_i (.core_clk, .rst, .latency, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Adjust, offering a reference each busy cycle that must be held off
  task automatic adj(input logic [2:0] tgt, input logic pv, input logic [47:0] pw);
    int bad;
    bad = 0;
    adj_target = tgt;
    push_word_valid = pv;
    push_word = pw;
    adj_req = 1'b1;
    @(posedge core_clk) #1;
    adj_req = 1'b0;
    for (int i = 0; i < 80 && adj_busy === 1'b1; i++) begin
      ref_req = 1'b1;
      if (op_stall !== 1'b1) bad++;
      @(posedge core_clk) #1;
      if (ref_done !== 1'b0) bad++;
    end
    ref_req = 1'b0;
    push_word_valid = 1'b0;
    @(posedge core_clk) #1;
    check(adj_busy, 1'b0, "adjustment finished");
    check(bad + (ref_done !== 1'b0), 0, "stall and hold-off");
  endtask

  task automatic rf(input dac_ref_e k, input logic st, pr, ix, db, ro, cp, iq, input logic [19:0] ln,
                    input logic signed [20:0] iv, input dac_cause_e ec, input logic [19:0] ea);
    ref_kind = k;
    ref_store = st;
    desc_present = pr;
    desc_indexed = ix;
    desc_double = db;
    desc_readonly = ro;
    copy_req = cp;
    index_req = iq;
    desc_length = ln;
    index_val = iv;
    ref_req = 1'b1;
    @(posedge core_clk) #1;
    ref_req = 1'b0;
    check(ref_done, 1'b1, "reference answered");
    check(intr, ec != DAC_CAUSE_NONE, "interrupt flag");
    check(intr_cause, ec, "cause code");
    check(abs_addr, ea, "absolute address");
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({adj_busy, top_reg_valid, second_reg_valid, stack_ptr}, {3'h0, DAC_SP_RESET}, "reset state");
    clk_en = 1'b0;
    ref_req = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    ref_req = 1'b0;
    clk_en = 1'b1;
    check(ref_done, 1'b0, "frozen by clock enable");
    adj(DAC_ADJ_10, 1'b1, W1);
    check({top_reg_valid, second_reg_valid, top_word}, {2'h2, W1}, "loaded top");
    adj(DAC_ADJ_00, 1'b0, 48'h000000000000);
    check({top_reg_valid, second_reg_valid, stack_ptr}, {2'h0, 20'h00001}, "after push-down");
    check(dac_mem_model_i.mem[1], W1, "pushed word");
    latency = 4'h5;
    adj(DAC_ADJ_10, 1'b0, 48'h000000000000);
    check({top_reg_valid, second_reg_valid, stack_ptr}, {2'h2, DAC_SP_RESET}, "after push-up");
    check(top_word, W1, "word pushed up");
    adj(DAC_ADJ_13, 1'b0, 48'h000000000000);
    adj(DAC_ADJ_12, 1'b0, 48'h000000000000);
    check({top_reg_valid, stack_ptr}, {1'h1, DAC_SP_RESET}, "no adjustment needed");
    adj(DAC_ADJ_02, 1'b0, 48'h000000000000);
    check({top_reg_valid, second_reg_valid, stack_ptr}, {2'h1, DAC_SP_RESET}, "top emptied");
    adj(DAC_ADJ_01, 1'b0, 48'h000000000000);
    check({top_reg_valid, second_reg_valid, second_word}, {2'h1, W1}, "top word in second");
    adj(DAC_ADJ_11, 1'b1, W2);
    check({top_reg_valid, second_reg_valid, top_word}, {2'h3, W2}, "both full");
    latency = 4'h0;
    adj(DAC_ADJ_00, 1'b0, 48'h000000000000);
    check({stack_ptr, dac_mem_model_i.mem[2]}, {20'h00002, W2}, "two pushed down");
    $display("Stack adjustment test finished");
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 0, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, BASE);
    rf(DAC_REF_SEGMENT, 0, 1, 0, 0, 0, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, BASE);
    rf(DAC_REF_LOCAL, 0, 1, 0, 0, 0, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, 20'hF0210);
    rf(DAC_REF_STACKBASE, 0, 1, 0, 0, 0, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, 20'hF3010);
    rf(DAC_REF_ARRAY, 0, 0, 0, 0, 0, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_PRESENCE, 20'h00000);
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 0, 0, 1, 20'h0000A, 21'sh5, DAC_CAUSE_NONE, BASE + 20'h5);
    check({out_indexed, out_length}, {1'h1, 20'h00005}, "indexed result");
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 0, 0, 1, 20'h0000A, 21'shA, DAC_CAUSE_NONE, BASE + 20'hA);
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 0, 0, 1, 20'h0000A, 21'shB, DAC_CAUSE_INDEX, 20'h00000);
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 0, 0, 1, 20'h0000A, -21'sh1, DAC_CAUSE_INDEX, 20'h00000);
    rf(DAC_REF_ARRAY, 0, 1, 0, 1, 0, 0, 1, 20'h0000A, 21'sh3, DAC_CAUSE_NONE, BASE + 20'h6);
    check(out_length, 20'h00006, "doubled index");
    rf(DAC_REF_ARRAY, 0, 1, 1, 0, 0, 0, 0, 20'h00007, 21'sh0, DAC_CAUSE_NONE, BASE + 20'h7);
    rf(DAC_REF_ARRAY, 1, 1, 0, 0, 1, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_READONLY, 20'h00000);
    rf(DAC_REF_ARRAY, 0, 1, 0, 0, 1, 0, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, BASE);
    rf(DAC_REF_ARRAY, 0, 0, 0, 0, 0, 0, 1, 20'h0000A, 21'shB, DAC_CAUSE_PRESENCE, 20'h00000);
    rf(DAC_REF_ARRAY, 0, 0, 0, 0, 0, 1, 0, 20'h0000A, 21'sh0, DAC_CAUSE_NONE, BASE);
    check({out_copy, out_addr}, {1'h1, MASTER}, "copy linked to master");
    $display("Reference test finished");
    stop_test();
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
endmodule
